// ---- bench/lcr_config_regs_checker.sv ----
// Port assertions for the configuration register bank
module lcr_config_regs_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Host pins
  input wire logic chip_select_n,
  input wire logic register_select,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  // Timing and configuration
  input wire logic scan_reverse,
  input wire logic timing_clock,
  input wire logic line_latch_out,
  input wire logic frame_marker_out,
  input wire logic frame_reverse_out,
  input wire logic display_clock_out,
  input wire logic [6:0] scan_start_common,
  input wire logic display_clock_enable,
  input wire logic duty_minus_one,
  input wire logic dummy_common_active,
  input wire logic [6:0] contrast_value,
  input wire logic [2:0] freq_trim_code,
  input wire logic [2:0] table_select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Multi-step behaviours
  sequence s_fwd;
    (!scan_reverse) [*5];
  endsequence
  sequence s_rev;
    scan_reverse [*5];
  endsequence
  sequence s_read;
    (!chip_select_n && register_select && !read_strobe_n) [*4];
  endsequence

  property p_gate_off;
    !display_clock_enable |=> !(line_latch_out | frame_marker_out | frame_reverse_out | display_clock_out);
  endproperty
  property p_gate_on;
    display_clock_enable && timing_clock |=> display_clock_out;
  endproperty
  property p_dummy;
    dummy_common_active == !duty_minus_one;
  endproperty
  property p_trim;
    freq_trim_code != lcr_pkg::FREQ_TRIM_INHIBITED;
  endproperty
  property p_scan_fwd;
    s_fwd |-> scan_start_common[1:0] == 2'h0 && scan_start_common <= 7'h70;
  endproperty
  property p_scan_rev;
    s_rev |-> scan_start_common[1:0] == 2'h3 && scan_start_common >= 7'h0F;
  endproperty
  property p_read_drive;
    s_read |-> !data_oe_n && data_out[7:4] == 4'h0;
  endproperty
  property p_idle_zero;
    data_oe_n |-> data_out == 8'h00;
  endproperty
  property p_write_cause;
    $changed(contrast_value) || $changed(table_select)
      |-> $past(write_strobe_n, 2) && !$past(write_strobe_n, 6) && !$past(chip_select_n, 3);
  endproperty
  property p_reset;
    $rose(nrst) |-> contrast_value == 7'h00 && table_select == 3'h0 && scan_start_common == 7'h00
      && freq_trim_code == 3'h0 && !duty_minus_one && !display_clock_enable;
  endproperty

  a_gate_off: assert property (p_gate_off) else $error("gated timing output high while disabled");
  a_gate_on: assert property (p_gate_on) else $error("display clock not passed while enabled");
  a_dummy: assert property (p_dummy) else $error("dummy common flag disagrees with duty bit");
  a_trim: assert property (p_trim) else $error("inhibited trim code applied");
  a_scan_fwd: assert property (p_scan_fwd) else $error("forward first common off grid");
  a_scan_rev: assert property (p_scan_rev) else $error("reverse first common off grid");
  a_read_drive: assert property (p_read_drive) else $error("read not answered");
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero while idle");
  a_write_cause: assert property (p_write_cause) else $error("register changed without a write");
  a_reset: assert property (p_reset) else $error("field not cleared by reset");
endmodule

bind lcr_config_regs lcr_config_regs_checker i_chk (.ref_clk, .nrst, .chip_select_n, .register_select,
  .read_strobe_n, .write_strobe_n, .data_out, .data_oe_n, .scan_reverse, .timing_clock, .line_latch_out,
  .frame_marker_out, .frame_reverse_out, .display_clock_out, .scan_start_common, .display_clock_enable,
  .duty_minus_one, .dummy_common_active, .contrast_value, .freq_trim_code, .table_select);

// ---- bench/lcr_host_model.sv ----
// Host processor model driving the instruction port pins
module lcr_host_model (
  // Clock
  input wire logic ref_clk,
  // Host pins
  output logic chip_select_n,
  output logic register_select,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] host_bus;

  // Resolved data bus level, device wins while driving
  assign data_in = data_oe_n ? host_bus : data_out;

  // Idle pin levels
  initial
  begin
    chip_select_n = 1'b1;
    register_select = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_bus = 8'h00;
  end

  // Instruction write, setup of three cycles and hold of four cycles around the strobe
  task wr(input logic [3:0] a, input logic [3:0] d, input logic rs_lvl);
    @(posedge ref_clk);
    chip_select_n <= 1'b0;
    register_select <= rs_lvl;
    host_bus <= {a, d};
    repeat (3) @(posedge ref_clk);
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chip_select_n <= 1'b1;
    host_bus <= ~{a, d};
  endtask

  // Register read, waits for the device to drive the bus
  task rd(output logic [7:0] v);
    int n;
    @(posedge ref_clk);
    chip_select_n <= 1'b0;
    register_select <= 1'b1;
    read_strobe_n <= 1'b0;
    n = 0;
    while (data_oe_n !== 1'b0 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    v = data_out;
    read_strobe_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chip_select_n <= 1'b1;
  endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking testbench for the configuration register bank
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
    if ((g) !== (e)) \
      failures++; \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  int failures = 0;
  int tests_run = 0;
  logic ref_clk, nrst, chip_select_n, register_select, read_strobe_n, write_strobe_n, data_oe_n;
  logic [7:0] data_in, data_out, v;
  logic scan_reverse, timing_line_latch, timing_frame_marker, timing_frame_reverse, timing_clock;
  logic line_latch_out, frame_marker_out, frame_reverse_out, display_clock_out, lookup_blue;
  logic [3:0] lookup_entry;
  logic [4:0] lookup_level;
  logic [6:0] scan_start_common, contrast_value;
  logic display_clock_enable, duty_minus_one, dummy_common_active, fixed_gray_select;
  logic eight_level_variable_select, bus_width_select, clock_source_select, abs_mode_enable;
  logic palette_bank_select;
  logic [2:0] freq_trim_code, table_select;

  // Device and host
  lcr_config_regs i_dut (.ref_clk, .nrst, .chip_select_n, .register_select, .read_strobe_n,
    .write_strobe_n, .data_in, .data_out, .data_oe_n, .scan_reverse, .timing_line_latch,
    .timing_frame_marker, .timing_frame_reverse, .timing_clock, .line_latch_out, .frame_marker_out,
    .frame_reverse_out, .display_clock_out, .lookup_blue, .lookup_entry, .lookup_level,
    .scan_start_common, .display_clock_enable, .duty_minus_one, .dummy_common_active,
    .fixed_gray_select, .eight_level_variable_select, .bus_width_select, .clock_source_select,
    .abs_mode_enable, .contrast_value, .freq_trim_code, .palette_bank_select, .table_select);
  lcr_host_model i_host (.ref_clk, .chip_select_n, .register_select, .read_strobe_n,
    .write_strobe_n, .data_in, .data_out, .data_oe_n);

  // 100 ns clock
  always #50 ref_clk = ~ref_clk;

  task stop_test;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [3:0] d);
    i_host.wr(a, d, 1'b1);
  endtask

  task chk_lk(input logic b, input logic [3:0] e, input logic [4:0] x);
    @(posedge ref_clk);
    lookup_blue <= b;
    lookup_entry <= e;
    repeat (2) @(posedge ref_clk);
    `CHK(lookup_level, x)
  endtask

  task t_reset;
    `CHK({scan_start_common, display_clock_enable, duty_minus_one, fixed_gray_select, eight_level_variable_select, bus_width_select, clock_source_select, abs_mode_enable, contrast_value, freq_trim_code, palette_bank_select, table_select}, 28'h0)
    `CHK(data_oe_n, 1'b1)
  endtask

  task t_palette;
    wr(4'hF, 4'h2);
    wr(4'h6, 4'hA);
    wr(4'h7, 4'hF);
    chk_lk(1'b0, 4'h2, 5'h1A);
    wr(4'hD, 4'h1);
    chk_lk(1'b0, 4'h5, 5'h10);
    wr(4'hF, 4'h3);
    wr(4'h2, 4'h7);
    chk_lk(1'b0, 4'h7, 5'h07);
    wr(4'h4, 4'h3);
    wr(4'h5, 4'h1);
    chk_lk(1'b1, 4'h0, 5'h13);
    wr(4'hF, 4'h5);
    wr(4'h9, 4'h1);
    `CHK(palette_bank_select, 1'b1)
    wr(4'hF, 4'h4);
    wr(4'h4, 4'hC);
    wr(4'h5, 4'h1);
    chk_lk(1'b1, 4'hF, 5'h1C);
    chk_lk(1'b1, 4'h7, 5'h00);
  endtask

  task t_cfg;
    wr(4'h7, 4'hE);
    `CHK({duty_minus_one, display_clock_enable, dummy_common_active}, 3'b100)
    timing_line_latch <= 1'b1;
    timing_frame_marker <= 1'b1;
    timing_frame_reverse <= 1'b1;
    timing_clock <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK({line_latch_out, frame_marker_out, frame_reverse_out, display_clock_out}, 4'h0)
    wr(4'h7, 4'h1);
    `CHK({duty_minus_one, display_clock_enable, dummy_common_active}, 3'b011)
    @(posedge ref_clk); // Gated outputs lag the enable by one cycle
    `CHK({line_latch_out, frame_marker_out, frame_reverse_out, display_clock_out}, 4'hF)
    wr(4'h8, 4'h4);
    `CHK({fixed_gray_select, eight_level_variable_select}, 2'b01)
    wr(4'h8, 4'h8);
    `CHK({fixed_gray_select, eight_level_variable_select}, 2'b10)
    wr(4'h9, 4'h5);
    `CHK({abs_mode_enable, clock_source_select, bus_width_select}, 3'b101)
    wr(4'h9, 4'hA);
    `CHK({abs_mode_enable, clock_source_select, bus_width_select}, 3'b010)
    wr(4'hC, 4'h9);
    i_host.rd(v);
    `CHK(v, 8'h02)
    wr(4'hC, 4'hF);
    i_host.rd(v);
    `CHK(v, 8'h04)
  endtask

  task t_scan;
    logic [6:0] idx;
    for (int c = 0; c < 16; c++)
    begin
      wr(4'h6, c[3:0]);
      @(posedge ref_clk); // First common lags the code by one cycle
      idx = (c < 2) ? 7'(4 * c) : 7'(8 * (c - 1));
      `CHK(scan_start_common, idx)
      scan_reverse <= 1'b1;
      repeat (5) @(posedge ref_clk);
      `CHK(scan_start_common, 7'h7F - idx)
      scan_reverse <= 1'b0;
    end
  endtask

  // Upper nibble first, then lower
  task t_contrast;
    wr(4'hA, 4'h3);
    `CHK(contrast_value, 7'h00)
    wr(4'hB, 4'h5);
    `CHK(contrast_value, 7'h00)
    wr(4'hA, 4'h3);
    `CHK(contrast_value, 7'h53)
    wr(4'hB, 4'hF);
    wr(4'hA, 4'h0);
    `CHK(contrast_value, 7'h70)
  endtask

  task t_trim;
    wr(4'hD, 4'hE);
    `CHK(freq_trim_code, 3'h6)
    wr(4'hD, 4'h7);
    `CHK(freq_trim_code, 3'h6)
    i_host.wr(4'hD, 4'h1, 1'b0);
    `CHK(freq_trim_code, 3'h6)
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_reset;
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  // Main sequence
  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    scan_reverse = 1'b0;
    timing_line_latch = 1'b0;
    timing_frame_marker = 1'b0;
    timing_frame_reverse = 1'b0;
    timing_clock = 1'b0;
    lookup_blue = 1'b0;
    lookup_entry = 4'h0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_palette;
    t_cfg;
    t_scan;
    t_contrast;
    t_trim;
    stop_test;
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    stop_test;
  end
endmodule

// ---- verilog/lcr_config_regs.sv ----
// Instruction register bank: green/blue palettes and display configuration
//
// Behaviour
// - Palette entry is five bits: even address bits 3..0, odd address bit 4.
// - Green entries 2..5 sit in table 2 at 6H..DH, two addresses each.
// - Green 6,7 at table 3 0H..3H; blue 0..4 at table 3 4H..DH.
// - Blue 5..7 at table 4 0H..5H; bank select adds eight to entry.
// - Scan-start code picks first common; reverse scan gives 127 minus index.
// - Clock enable low holds latch, frame marker, frame reverse, clock low.
// - Duty-minus-one set removes the dummy common timing.
// - Duty-minus-one clear: dummy timing non-select, segments repeat last line.
// - Address 8H bit 3 fixed 8-level; bit 2 variable 8 or 16 level.
// - Address 9H bit 0 selects 8-bit or 16-bit display data bus.
// - Address 9H bit 1 selects internal or external clock source.
// - Address 9H bit 2 turns absolute mode on.
// - Contrast applies only after both nibbles are written, never half.
// - Frequency trim code 111 is inhibited; such writes are ignored.
// - Reset clears every configuration field to zero, except the read pointer, which resets to BH.
// - Address FH selects the active table; other addresses decode in it.
// - Palette bank select picks lower or upper palette entries.
// - Register read returns the register named by the read pointer.
module lcr_config_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Host port pins
  input wire logic chip_select_n,
  input wire logic register_select,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  // Scan direction from display control
  input wire logic scan_reverse,
  // Timing generator raw outputs
  input wire logic timing_line_latch,
  input wire logic timing_frame_marker,
  input wire logic timing_frame_reverse,
  input wire logic timing_clock,
  // Gated display timing outputs
  output logic line_latch_out,
  output logic frame_marker_out,
  output logic frame_reverse_out,
  output logic display_clock_out,
  // Palette lookup from the grayscale engine
  input wire logic lookup_blue,
  input wire logic [3:0] lookup_entry,
  output logic [4:0] lookup_level,
  // Configuration towards the display core
  output logic [6:0] scan_start_common,
  output logic display_clock_enable,
  output logic duty_minus_one,
  output logic dummy_common_active,
  output logic fixed_gray_select,
  output logic eight_level_variable_select,
  output logic bus_width_select,
  output logic clock_source_select,
  output logic abs_mode_enable,
  output logic [6:0] contrast_value,
  output logic [2:0] freq_trim_code,
  output logic palette_bank_select,
  output logic [2:0] table_select
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------

  // Palette decode: {hit, blue, entry[2:0], high_half}
  function automatic logic [5:0] palette_decode(input logic [2:0] tbl, input logic [3:0] addr);
    logic [2:0] ent;
    logic hit;
    logic blue;
    ent = 3'h0;
    hit = 1'b0;
    blue = 1'b0;
    if (tbl == lcr_pkg::TABLE_GREEN_LO && addr >= lcr_pkg::ADDR_GREEN_LO_BASE
        && addr <= lcr_pkg::ADDR_GREEN_LO_LAST)
    begin
      hit = 1'b1;
      ent = 3'((addr - lcr_pkg::ADDR_GREEN_LO_BASE) >> 1) + lcr_pkg::GREEN_LO_FIRST_ENTRY;
    end
    else if (tbl == lcr_pkg::TABLE_MIXED && addr <= lcr_pkg::ADDR_GREEN_HI_LAST)
    begin
      hit = 1'b1;
      ent = 3'(addr >> 1) + lcr_pkg::GREEN_HI_FIRST_ENTRY;
    end
    else if (tbl == lcr_pkg::TABLE_MIXED && addr >= lcr_pkg::ADDR_BLUE_LO_BASE
             && addr <= lcr_pkg::ADDR_BLUE_LO_LAST)
    begin
      hit = 1'b1;
      blue = 1'b1;
      ent = 3'((addr - lcr_pkg::ADDR_BLUE_LO_BASE) >> 1);
    end
    else if (tbl == lcr_pkg::TABLE_CONFIG && addr <= lcr_pkg::ADDR_BLUE_HI_LAST)
    begin
      hit = 1'b1;
      blue = 1'b1;
      ent = 3'(addr >> 1) + lcr_pkg::BLUE_HI_FIRST_ENTRY;
    end
    palette_decode = {hit, blue, ent, addr[0]};
  endfunction

  // First scanned common from scan-start code and direction
  function automatic logic [6:0] scan_index(input logic [3:0] code, input logic rev);
    logic [6:0] idx;
    idx = (code < 4'h2) ? 7'({code[0], 2'h0}) : 7'({code - 4'h1, 3'h0});
    scan_index = rev ? (lcr_pkg::LAST_COMMON - idx) : idx;
  endfunction

  // ------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  logic [11:0] pin_meta_reg;
  logic [11:0] pin_sync_reg;
  logic wr_prev_reg;
  logic cs_n_s;
  logic rs_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [7:0] data_s;

  // Two-flop capture of every host pin
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= 12'hF00;
      pin_sync_reg <= 12'hF00;
      wr_prev_reg <= 1'b1;
    end
    else
    begin
      pin_meta_reg <= {chip_select_n, register_select, read_strobe_n, write_strobe_n, data_in};
      pin_sync_reg <= pin_meta_reg;
      wr_prev_reg <= pin_sync_reg[8];
    end
  end

  assign cs_n_s = pin_sync_reg[11];
  assign rs_s = pin_sync_reg[10];
  assign rd_n_s = pin_sync_reg[9];
  assign wr_n_s = pin_sync_reg[8];
  assign data_s = pin_sync_reg[7:0];

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  logic wr_event;
  logic [3:0] wr_addr;
  logic [3:0] wr_nib;
  logic [5:0] wr_pal;
  logic in_config;

  // Instruction taken at the end of the write strobe
  assign wr_event = !wr_prev_reg && wr_n_s && !cs_n_s && rs_s;
  assign wr_addr = data_s[7:4];
  assign wr_nib = data_s[3:0];
  assign wr_pal = palette_decode(table_select, wr_addr);
  assign in_config = table_select == lcr_pkg::TABLE_CONFIG;

  // ------------------------------------------------------------
  // Table select, bank select, read pointer
  // ------------------------------------------------------------
  logic [3:0] read_pointer_reg;

  // Table select decodes in every table
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      table_select <= lcr_pkg::TABLE_SELECT_RESET;
    else if (wr_event && wr_addr == lcr_pkg::ADDR_TABLE_SELECT)
      table_select <= wr_nib[2:0];
  end

  // Palette bank select
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      palette_bank_select <= 1'b0;
    else if (wr_event && table_select == lcr_pkg::TABLE_PALSEL && wr_addr == lcr_pkg::ADDR_PALETTE_BANK)
      palette_bank_select <= wr_nib[lcr_pkg::BIT_PALETTE_BANK];
  end

  // Read pointer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      read_pointer_reg <= lcr_pkg::READ_POINTER_RESET;
    else if (wr_event && in_config && wr_addr == lcr_pkg::ADDR_READ_POINTER)
      read_pointer_reg <= wr_nib;
  end

  // ------------------------------------------------------------
  // Palette storage, 16 entries per colour
  // ------------------------------------------------------------
  logic [4:0] green_mem [16];
  logic [4:0] blue_mem [16];
  logic [3:0] wr_slot;

  assign wr_slot = {palette_bank_select, wr_pal[3:1]};

  // Palette writes, low nibble or top bit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
      begin
        green_mem[i] <= lcr_pkg::PALETTE_RESET;
        blue_mem[i] <= lcr_pkg::PALETTE_RESET;
      end
    end
    else if (wr_event && wr_pal[5])
    begin
      if (wr_pal[4])
      begin
        if (wr_pal[0])
          blue_mem[wr_slot][4] <= wr_nib[lcr_pkg::BIT_PALETTE_MSB];
        else
          blue_mem[wr_slot][3:0] <= wr_nib;
      end
      else
      begin
        if (wr_pal[0])
          green_mem[wr_slot][4] <= wr_nib[lcr_pkg::BIT_PALETTE_MSB];
        else
          green_mem[wr_slot][3:0] <= wr_nib;
      end
    end
  end

  // Palette lookup port
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lookup_level <= lcr_pkg::PALETTE_RESET;
    else
      lookup_level <= lookup_blue ? blue_mem[lookup_entry] : green_mem[lookup_entry];
  end

  // ------------------------------------------------------------
  // Configuration fields in table 4
  // ------------------------------------------------------------
  logic [3:0] scan_code_reg;

  // Scan-start, duty, clock gate, grayscale, bus and oscillator
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scan_code_reg <= lcr_pkg::NIBBLE_RESET;
      display_clock_enable <= 1'b0;
      duty_minus_one <= 1'b0;
      fixed_gray_select <= 1'b0;
      eight_level_variable_select <= 1'b0;
      bus_width_select <= 1'b0;
      clock_source_select <= 1'b0;
      abs_mode_enable <= 1'b0;
    end
    else if (wr_event && in_config)
    begin
      unique case (wr_addr)
        lcr_pkg::ADDR_SCAN_START:
          scan_code_reg <= wr_nib;
        lcr_pkg::ADDR_DUTY_CLOCK:
        begin
          display_clock_enable <= wr_nib[lcr_pkg::BIT_CLOCK_ENABLE];
          duty_minus_one <= wr_nib[lcr_pkg::BIT_DUTY_MINUS_ONE];
        end
        lcr_pkg::ADDR_GRAY_MODE:
        begin
          fixed_gray_select <= wr_nib[lcr_pkg::BIT_FIXED_GRAY];
          eight_level_variable_select <= wr_nib[lcr_pkg::BIT_EIGHT_LEVEL];
        end
        lcr_pkg::ADDR_BUS_OSC:
        begin
          bus_width_select <= wr_nib[lcr_pkg::BIT_BUS_WIDTH];
          clock_source_select <= wr_nib[lcr_pkg::BIT_CLOCK_SOURCE];
          abs_mode_enable <= wr_nib[lcr_pkg::BIT_ABS_MODE];
        end
        default:
        begin
        end
      endcase
    end
  end

  // First scanned common
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      scan_start_common <= 7'h00;
    else
      scan_start_common <= scan_index(scan_code_reg, scan_reverse);
  end

  // Extra dummy common only while duty-minus-one is clear
  assign dummy_common_active = !duty_minus_one;

  // ------------------------------------------------------------
  // Contrast: staged nibbles, applied as a pair
  // ------------------------------------------------------------
  logic [3:0] contrast_lo_reg;
  logic [2:0] contrast_hi_reg;
  logic contrast_armed_reg;

  // Upper nibble arms, lower nibble commits
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      contrast_lo_reg <= lcr_pkg::NIBBLE_RESET;
      contrast_hi_reg <= 3'h0;
      contrast_armed_reg <= 1'b0;
      contrast_value <= lcr_pkg::CONTRAST_RESET;
    end
    else if (wr_event && in_config && wr_addr == lcr_pkg::ADDR_CONTRAST_HI)
    begin
      contrast_hi_reg <= wr_nib[2:0];
      contrast_armed_reg <= 1'b1;
    end
    else if (wr_event && in_config && wr_addr == lcr_pkg::ADDR_CONTRAST_LO)
    begin
      contrast_lo_reg <= wr_nib;
      contrast_armed_reg <= 1'b0;
      if (contrast_armed_reg)
        contrast_value <= {contrast_hi_reg, wr_nib};
    end
  end

  // ------------------------------------------------------------
  // Frequency trim
  // ------------------------------------------------------------

  // Inhibited code leaves the old value
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      freq_trim_code <= lcr_pkg::FREQ_TRIM_RESET;
    else if (wr_event && in_config && wr_addr == lcr_pkg::ADDR_FREQ_TRIM
             && wr_nib[2:0] != lcr_pkg::FREQ_TRIM_INHIBITED)
      freq_trim_code <= wr_nib[2:0];
  end

  // ------------------------------------------------------------
  // Display timing gate
  // ------------------------------------------------------------

  // Outputs held low while the display clock is off
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_latch_out <= 1'b0;
      frame_marker_out <= 1'b0;
      frame_reverse_out <= 1'b0;
      display_clock_out <= 1'b0;
    end
    else
    begin
      line_latch_out <= display_clock_enable && timing_line_latch;
      frame_marker_out <= display_clock_enable && timing_frame_marker;
      frame_reverse_out <= display_clock_enable && timing_frame_reverse;
      display_clock_out <= display_clock_enable && timing_clock;
    end
  end

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  logic [5:0] rd_pal;
  logic [3:0] rd_slot;
  logic [4:0] rd_entry;
  logic [3:0] rd_nib;
  logic rd_active;

  assign rd_pal = palette_decode(table_select, read_pointer_reg);
  assign rd_slot = {palette_bank_select, rd_pal[3:1]};
  assign rd_entry = rd_pal[4] ? blue_mem[rd_slot] : green_mem[rd_slot];
  assign rd_active = !cs_n_s && rs_s && !rd_n_s;

  // Readback mux, unused bits zero
  always_comb
  begin
    rd_nib = 4'h0;
    if (read_pointer_reg == lcr_pkg::ADDR_TABLE_SELECT)
      rd_nib = {1'b0, table_select};
    else if (rd_pal[5])
      rd_nib = rd_pal[0] ? {3'h0, rd_entry[4]} : rd_entry[3:0];
    else if (table_select == lcr_pkg::TABLE_PALSEL && read_pointer_reg == lcr_pkg::ADDR_PALETTE_BANK)
      rd_nib = {3'h0, palette_bank_select};
    else if (in_config)
    begin
      unique case (read_pointer_reg)
        lcr_pkg::ADDR_SCAN_START: rd_nib = scan_code_reg;
        lcr_pkg::ADDR_DUTY_CLOCK: rd_nib = {2'h0, duty_minus_one, display_clock_enable};
        lcr_pkg::ADDR_GRAY_MODE: rd_nib = {fixed_gray_select, eight_level_variable_select, 2'h0};
        lcr_pkg::ADDR_BUS_OSC: rd_nib = {1'b0, abs_mode_enable, clock_source_select, bus_width_select};
        lcr_pkg::ADDR_CONTRAST_LO: rd_nib = contrast_lo_reg;
        lcr_pkg::ADDR_CONTRAST_HI: rd_nib = {1'b0, contrast_hi_reg};
        lcr_pkg::ADDR_FREQ_TRIM: rd_nib = {1'b0, freq_trim_code};
        default: rd_nib = 4'h0;
      endcase
    end
  end

  // Drive the bus while a read strobe is seen
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end
    else
    begin
      data_out <= rd_active ? {4'h0, rd_nib} : 8'h00;
      data_oe_n <= !rd_active;
    end
  end

endmodule

// ---- verilog/lcr_pkg.sv ----
// Constants for the LCD driver configuration register bank
package lcr_pkg;

  // ------------------------------------------------------------
  // Instruction tables
  // ------------------------------------------------------------
  localparam logic [2:0] TABLE_GREEN_LO = 3'h2;
  localparam logic [2:0] TABLE_MIXED = 3'h3;
  localparam logic [2:0] TABLE_CONFIG = 3'h4;
  localparam logic [2:0] TABLE_PALSEL = 3'h5;

  // ------------------------------------------------------------
  // Register addresses (4-bit, decoded inside the current table, except FH, which decodes in every table)
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_TABLE_SELECT = 4'hF;
  localparam logic [3:0] ADDR_SCAN_START = 4'h6;
  localparam logic [3:0] ADDR_DUTY_CLOCK = 4'h7;
  localparam logic [3:0] ADDR_GRAY_MODE = 4'h8;
  localparam logic [3:0] ADDR_BUS_OSC = 4'h9;
  localparam logic [3:0] ADDR_CONTRAST_LO = 4'hA;
  localparam logic [3:0] ADDR_CONTRAST_HI = 4'hB;
  localparam logic [3:0] ADDR_READ_POINTER = 4'hC;
  localparam logic [3:0] ADDR_FREQ_TRIM = 4'hD;
  localparam logic [3:0] ADDR_PALETTE_BANK = 4'h9;

  // Palette windows: first and last address of each run inside its table, and first entry of each run
  localparam logic [3:0] ADDR_GREEN_LO_BASE = 4'h6;
  localparam logic [3:0] ADDR_GREEN_LO_LAST = 4'hD;
  localparam logic [3:0] ADDR_GREEN_HI_LAST = 4'h3;
  localparam logic [3:0] ADDR_BLUE_LO_BASE = 4'h4;
  localparam logic [3:0] ADDR_BLUE_LO_LAST = 4'hD;
  localparam logic [3:0] ADDR_BLUE_HI_LAST = 4'h5;
  localparam logic [2:0] GREEN_LO_FIRST_ENTRY = 3'h2;
  localparam logic [2:0] GREEN_HI_FIRST_ENTRY = 3'h6;
  localparam logic [2:0] BLUE_HI_FIRST_ENTRY = 3'h5;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_CLOCK_ENABLE = 0;
  localparam int BIT_DUTY_MINUS_ONE = 1;
  localparam int BIT_EIGHT_LEVEL = 2;
  localparam int BIT_FIXED_GRAY = 3;
  localparam int BIT_BUS_WIDTH = 0;
  localparam int BIT_CLOCK_SOURCE = 1;
  localparam int BIT_ABS_MODE = 2;
  localparam int BIT_PALETTE_BANK = 0;
  localparam int BIT_PALETTE_MSB = 0;

  // ------------------------------------------------------------
  // Reset values and special codes
  // ------------------------------------------------------------
  localparam logic [2:0] TABLE_SELECT_RESET = 3'h0;
  localparam logic [3:0] READ_POINTER_RESET = 4'hB;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [6:0] CONTRAST_RESET = 7'h00;
  localparam logic [2:0] FREQ_TRIM_RESET = 3'h0;
  localparam logic [2:0] FREQ_TRIM_INHIBITED = 3'h7;
  localparam logic [4:0] PALETTE_RESET = 5'h00;
  localparam logic [6:0] LAST_COMMON = 7'h7F;

endpackage
